// >>> verilog/watchdog_pkg.sv
// constants, register map and types of the windowed watchdog timer
// assumes a 50 MHz system clock and an AXI4-Lite register port
package watchdog_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int OSC_HZ = 32_000;
	localparam int OSC_DIV = CLK_HZ / OSC_HZ;
	localparam int PRE_DIV_SHORT = 32;
	localparam int PRE_DIV_LONG = 128;
	localparam int POST_LOG_MAX = 15;
	localparam int BASE_TIMEOUT_SHORT_US = 1000;
	localparam int BASE_TIMEOUT_LONG_US = 4000;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CONFIG_OFS = 8'h00;
	localparam logic [7:0] RESET_CONTROL_OFS = 8'h04;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
	localparam logic [7:0] COUNT_OFS = 8'h10;
	localparam int CFG_POST_LSB = 0;
	localparam int CFG_PRE_BIT = 4;
	localparam int CFG_WIN_DIS_BIT = 6;
	localparam int CFG_HW_EN_BIT = 7;
	localparam logic [7:0] CONFIG_RESET = 8'h5f;
	localparam int RC_IDLE_BIT = 2;
	localparam int RC_SLEEP_BIT = 3;
	localparam int RC_TIMEOUT_BIT = 4;
	localparam int RC_SW_EN_BIT = 5;
	localparam int IRQ_W = 3;
	localparam int IRQ_TIMEOUT_BIT = 0;
	localparam int IRQ_WINDOW_BIT = 1;
	localparam int IRQ_WAKE_BIT = 2;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
	localparam int COUNT_WINDOW_BIT = 31;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		MODE_RUN = 3'b001,
		MODE_SLEEP = 3'b010,
		MODE_IDLE = 3'b100
	} mode_t;
endpackage : watchdog_pkg

// >>> verilog/watchdog_counter.sv
// combined prescaler and postscaler count of the watchdog
// assumes tick is a one-cycle pulse at the low-power oscillator rate
`timescale 1ns/1ns
module watchdog_counter #(
	parameter int PRE_SHORT = watchdog_pkg::PRE_DIV_SHORT,
	parameter int PRE_LONG = watchdog_pkg::PRE_DIV_LONG,
	parameter int POST_LOG = watchdog_pkg::POST_LOG_MAX,
	parameter int CW = $clog2(PRE_LONG) + POST_LOG
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tick,
	input wire logic clear,
	input wire logic run,
	input wire logic prescale_select,
	input wire logic [3:0] postscale_select,
	output logic timeout,
	output logic in_window,
	output logic [CW-1:0] count
);
	import watchdog_pkg::*;

	if (PRE_SHORT < 1 || PRE_LONG < PRE_SHORT || POST_LOG != 15 ||
		(PRE_LONG & (PRE_LONG - 1)) != 0 ||
		(PRE_SHORT & (PRE_SHORT - 1)) != 0) begin : g_bad
		$error("watchdog_counter: unsupported divider parameters");
	end

	typedef struct packed {
		logic [CW-1:0] count;
		logic timeout;
	} cnt_state_t;

	cnt_state_t q, d;
	logic [CW:0] total;
	logic [CW:0] cnt_ext;

	always_comb begin
		// a single count spans both stages; its low bits are the prescaler
		total = (prescale_select ? (CW+1)'(PRE_LONG) : (CW+1)'(PRE_SHORT))
			<< postscale_select; // [RULE2] [RULE4]
		cnt_ext = {1'b0, q.count};
		d = q;
		d.timeout = 1'b0;
		if (clear) begin
			d.count = '0; // [RULE5] [RULE6] [RULE7]
		end else if (run && tick) begin
			if (cnt_ext == total - (CW+1)'(1)) begin
				d.count = '0;
				d.timeout = 1'b1; // [RULE3]
			end else begin
				d.count = q.count + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0; // [RULE5]
		end else if (ce) begin
			q <= d;
		end
	end

	// last quarter of the selected period
	assign in_window = cnt_ext >= total - (total >> 2); // [RULE14]
	assign timeout = q.timeout;
	assign count = q.count;
endmodule : watchdog_counter

// >>> verilog/windowed_watchdog_timer.sv
// windowed watchdog timer with AXI4-Lite registers and interrupt
// assumes core events are one-cycle pulses synchronous to clk
//
// Summary of operation
// RULE1: watchdog runs from the low-power oscillator, switched on by enable.
// RULE2: prescaler divides by 32 or 128 per the prescale select bit.
// RULE3: base period is 1 ms or 4 ms from the 32 kHz clock.
// RULE4: postscaler divides further by 1:1 to 1:32768, 4-bit select.
// RULE5: counts clear on device reset and completed clock switch.
// RULE6: counts clear on power-save entry and on exit back to run.
// RULE7: clear instruction in normal run resets all watchdog counts.
// RULE8: counts keep running in sleep and idle; timeout wakes the core.
// RULE9: software clears the sleep and idle status bits after wake.
// RULE10: timeout flag stays set until software clears it.
// RULE11: hardware enable set keeps the watchdog running always.
// RULE12: with hardware enable clear, software enable bit decides running.
// RULE13: software enable bit clears on any device reset.
// RULE14: without window disable, early clear instruction causes reset.
// RULE15: timeout in normal run resets the device and sets the flag.
`timescale 1ns/1ns
module windowed_watchdog_timer #(
	parameter int OSC_DIV = watchdog_pkg::OSC_DIV
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [watchdog_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [watchdog_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic clear_watchdog_instruction,
	input wire logic power_save_instruction,
	input wire logic power_save_idle,
	input wire logic clock_switch_done,
	input wire logic device_reset,
	input wire logic wake_exit,
	output logic low_power_rc_clock_enable,
	output logic watchdog_reset,
	output logic wake_request,
	output logic irq
);
	import watchdog_pkg::*;

	localparam int DIVW = $clog2(OSC_DIV + 1);
	localparam int CW = $clog2(PRE_DIV_LONG) + POST_LOG_MAX;

	if (OSC_DIV < 1 || ADDR_W < 5 || CW > 31) begin : g_bad
		$error("windowed_watchdog_timer: unsupported parameters");
	end
	if (PRE_DIV_SHORT * 1_000_000 / OSC_HZ != BASE_TIMEOUT_SHORT_US ||
		PRE_DIV_LONG * 1_000_000 / OSC_HZ != BASE_TIMEOUT_LONG_US)
	begin : g_period
		$error("windowed_watchdog_timer: base period mismatch");
	end

	typedef struct packed {
		logic [7:0] cfg;
		logic sw_en;
		logic timeout_flag;
		logic sleep_flag;
		logic idle_flag;
		mode_t mode;
		logic [DIVW-1:0] div;
		logic tick;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic aw_held;
		logic [ADDR_W-1:0] awaddr;
		logic w_held;
		logic [7:0] wdata;
		logic wlane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic wdt_reset;
		logic wake;
	} top_state_t;

	top_state_t q, d;
	logic enable;
	logic cnt_clear;
	logic cnt_timeout;
	logic in_window;
	logic [CW-1:0] cnt_value;
	logic running;
	logic entry;
	logic exit_ps;
	logic fire_reset;
	logic window_violation;
	logic wake_event;
	logic [IRQ_W-1:0] irq_set;
	logic wr_go;

	function automatic logic [32:0] read_word(input top_state_t s,
		input logic [ADDR_W-1:0] addr, input logic [CW-1:0] cnt,
		input logic win);
		logic [31:0] w;
		logic err;
		w = '0;
		err = 1'b0;
		case (addr)
			ADDR_W'(CONFIG_OFS): w[7:0] = s.cfg;
			ADDR_W'(RESET_CONTROL_OFS): begin
				w[RC_SW_EN_BIT] = s.sw_en;
				w[RC_TIMEOUT_BIT] = s.timeout_flag;
				w[RC_SLEEP_BIT] = s.sleep_flag;
				w[RC_IDLE_BIT] = s.idle_flag;
			end
			ADDR_W'(IRQ_STATUS_OFS): w[IRQ_W-1:0] = s.irq_status;
			ADDR_W'(IRQ_MASK_OFS): w[IRQ_W-1:0] = s.irq_mask;
			ADDR_W'(COUNT_OFS): begin
				w[CW-1:0] = cnt;
				w[COUNT_WINDOW_BIT] = win;
			end
			default: err = 1'b1;
		endcase
		return {err, w};
	endfunction : read_word

	// hardware enable wins over software control
	assign enable = q.cfg[CFG_HW_EN_BIT] | q.sw_en; // [RULE11] [RULE12]
	assign running = q.mode == MODE_RUN;
	assign entry = running && power_save_instruction;
	// the counter keeps ticking in sleep and idle while enabled
	assign wake_event = !running && cnt_timeout; // [RULE8]
	assign exit_ps = !running && (cnt_timeout || wake_exit); // [RULE6]
	assign window_violation = running && enable && clear_watchdog_instruction
		&& !q.cfg[CFG_WIN_DIS_BIT] && !in_window; // [RULE14]
	assign fire_reset = running && (cnt_timeout || window_violation);
	assign cnt_clear = device_reset || clock_switch_done // [RULE5]
		|| entry || exit_ps // [RULE6]
		|| (running && clear_watchdog_instruction) // [RULE7]
		|| fire_reset;
	assign irq_set = {wake_event, window_violation, cnt_timeout};
	assign wr_go = q.aw_held && q.w_held && !q.bvalid;

	watchdog_counter #(
		.PRE_SHORT(PRE_DIV_SHORT),
		.PRE_LONG(PRE_DIV_LONG),
		.POST_LOG(POST_LOG_MAX),
		.CW(CW)
	) u_counter (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.tick(q.tick),
		.clear(cnt_clear),
		.run(enable),
		.prescale_select(q.cfg[CFG_PRE_BIT]),
		.postscale_select(q.cfg[CFG_POST_LSB +: 4]),
		.timeout(cnt_timeout),
		.in_window(in_window),
		.count(cnt_value)
	);

	always_comb begin
		logic [32:0] rd;
		rd = read_word(q, s_axi_araddr, cnt_value, in_window);
		d = q;
		d.tick = 1'b0;
		d.wdt_reset = 1'b0;
		d.wake = 1'b0;
		// oscillator tick only while enabled, to save power
		if (!enable) begin
			d.div = '0;
		end else if (q.div == DIVW'(OSC_DIV - 1)) begin
			d.div = '0;
			d.tick = 1'b1; // [RULE1]
		end else begin
			d.div = q.div + DIVW'(1);
		end
		// register bus
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_held = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_held = 1'b1;
			d.wdata = s_axi_wdata[7:0];
			d.wlane0 = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (wr_go) begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			case (q.awaddr)
				ADDR_W'(CONFIG_OFS): if (q.wlane0) begin
					d.cfg = q.wdata;
					// once set, software cannot drop the hardware enable
					d.cfg[CFG_HW_EN_BIT] = q.cfg[CFG_HW_EN_BIT]
						| q.wdata[CFG_HW_EN_BIT]; // [RULE11]
				end
				ADDR_W'(RESET_CONTROL_OFS): if (q.wlane0) begin
					d.sw_en = q.wdata[RC_SW_EN_BIT]; // [RULE12]
					d.timeout_flag = q.wdata[RC_TIMEOUT_BIT]; // [RULE10]
					d.sleep_flag = q.wdata[RC_SLEEP_BIT]; // [RULE9]
					d.idle_flag = q.wdata[RC_IDLE_BIT]; // [RULE9]
				end
				ADDR_W'(IRQ_STATUS_OFS): if (q.wlane0) begin
					d.irq_status = q.irq_status & ~q.wdata[IRQ_W-1:0];
				end
				ADDR_W'(IRQ_MASK_OFS): if (q.wlane0) begin
					d.irq_mask = q.wdata[IRQ_W-1:0];
				end
				ADDR_W'(COUNT_OFS): d.bresp = RESP_OKAY;
				default: d.bresp = RESP_SLVERR;
			endcase
		end
		if (s_axi_rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			d.rvalid = 1'b1;
			d.rdata = rd[31:0];
			d.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
		end
		// hardware sets after software writes, so a set is never lost
		d.irq_status = d.irq_status | irq_set;
		if (cnt_timeout) begin
			d.timeout_flag = 1'b1; // [RULE10] [RULE15]
		end
		// power-save state; status bits are left for software to clear
		case (q.mode)
			MODE_RUN: if (entry) begin
				d.mode = power_save_idle ? MODE_IDLE : MODE_SLEEP;
				if (power_save_idle) begin
					d.idle_flag = 1'b1;
				end else begin
					d.sleep_flag = 1'b1;
				end
			end
			MODE_SLEEP, MODE_IDLE: if (exit_ps) begin
				d.mode = MODE_RUN;
				d.wake = wake_event; // [RULE8]
			end
			default: d.mode = MODE_RUN;
		endcase
		if (fire_reset) begin
			d.wdt_reset = 1'b1; // [RULE15] [RULE14]
		end
		if (device_reset || fire_reset) begin
			d.sw_en = 1'b0; // [RULE13]
			d.mode = MODE_RUN;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.cfg <= CONFIG_RESET;
			q.mode <= MODE_RUN;
			q.irq_mask <= IRQ_MASK_RESET;
			q.bresp <= RESP_OKAY;
			q.rresp <= RESP_OKAY;
		end else if (ce) begin
			q <= d;
		end
	end

	// one write and one read outstanding; ce low also stalls the bus
	assign s_axi_awready = ce && !q.aw_held && !q.bvalid;
	assign s_axi_wready = ce && !q.w_held && !q.bvalid;
	assign s_axi_arready = ce && !q.rvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign low_power_rc_clock_enable = enable; // [RULE1]
	assign watchdog_reset = q.wdt_reset;
	assign wake_request = q.wake;
	assign irq = |(q.irq_status & q.irq_mask);
endmodule : windowed_watchdog_timer

// >>> tb/watchdog_props.sv
// checker for the windowed watchdog timer, bound to its top ports
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ns
module watchdog_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic low_power_rc_clock_enable,
	input wire logic watchdog_reset,
	input wire logic wake_request,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce
		|=> s_axi_rvalid) else $error("read answer late");
	a_write_answer: assert property ((s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready && ce) ##1 ce |=> s_axi_bvalid)
		else $error("write answer late");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("write answer dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_ce_stalls: assert property (!ce |-> !s_axi_awready && !s_axi_wready
		&& !s_axi_arready) else $error("ready while stalled");
	a_reset_pulse: assert property (watchdog_reset
		|=> !watchdog_reset && !wake_request) else $error("reset too long");
	a_wake_pulse: assert property (wake_request
		|=> !wake_request && !watchdog_reset) else $error("wake too long");
	a_osc_running: assert property (watchdog_reset || wake_request
		|-> $past(low_power_rc_clock_enable)) else $error("osc was off");
	c_reset: cover property (watchdog_reset);
	c_wake: cover property (wake_request);
	c_irq: cover property (irq);
endmodule : watchdog_props
bind windowed_watchdog_timer watchdog_props watchdog_props_inst (.*);

// >>> tb/core_model.sv
// processor core model issuing clear, power-save and reset events
// assumes fire is called just after a rising edge of clk
`timescale 1ns/1ns
module core_model (
	input wire logic clk,
	output logic clear_watchdog_instruction,
	output logic power_save_instruction,
	output logic power_save_idle,
	output logic clock_switch_done,
	output logic device_reset,
	output logic wake_exit
);
	initial begin
		clear_watchdog_instruction = 1'b0;
		power_save_instruction = 1'b0;
		power_save_idle = 1'b0;
		clock_switch_done = 1'b0;
		device_reset = 1'b0;
		wake_exit = 1'b0;
	end
	// 0 clear, 1 sleep, 2 idle, 3 clock switch, 4 device reset
	task automatic fire(input int k);
		case (k)
		0: clear_watchdog_instruction <= 1'b1;
		1, 2: begin
			power_save_instruction <= 1'b1;
			power_save_idle <= (k == 2);
		end
		3: clock_switch_done <= 1'b1;
		5: wake_exit <= 1'b1;
		default: device_reset <= 1'b1;
		endcase
		@(posedge clk);
		clear_watchdog_instruction <= 1'b0;
		power_save_instruction <= 1'b0;
		clock_switch_done <= 1'b0;
		device_reset <= 1'b0;
		wake_exit <= 1'b0;
	endtask : fire
endmodule : core_model

// >>> tb/tb_top.sv
// self-checking bench for the windowed watchdog timer
// assumes oscillator divider of 1, so one count tick per clock
`timescale 1ns/1ns
module tb_top;
	import watchdog_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, low_power_rc_clock_enable;
	logic watchdog_reset, wake_request, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic clear_watchdog_instruction, power_save_instruction;
	logic power_save_idle, clock_switch_done, device_reset, wake_exit;
	int err_total = 0, n_checks = 0, cyc;
	logic [31:0] cfgs [3] = '{32'h41, 32'h50, 32'h40};
	int per [3] = '{64, 128, 32};
	always #10 clk = ~clk;
	windowed_watchdog_timer #(.OSC_DIV(1)) windowed_watchdog_timer_inst (.*);
	core_model core_model_inst (.*);
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk("bresp", RESP_OKAY, s_axi_bresp);
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk("rdata", e, s_axi_rdata);
		chk("rresp", a > 8'h10 ? RESP_SLVERR : RESP_OKAY, s_axi_rresp);
	endtask : axr
	// a missing pulse simply runs the limit out and shows in the count
	task automatic waitp(input int lim);
		cyc = 0;
		while (!watchdog_reset && !wake_request && cyc < lim) begin
			@(posedge clk);
			cyc++;
		end
	endtask : waitp
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#400000;
		err_total++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		axr(8'h00, 32'h5f);
		axr(8'h04, 32'h0);
		axr(8'h14, 32'h0);
		axw(8'h0c, 32'h7);
		$display("test 1 done");
		foreach (cfgs[i]) begin
			axw(8'h00, cfgs[i]);
			axw(8'h04, 32'h20);
			chk("osc_on", 1, low_power_rc_clock_enable);
			waitp(400);
			chk("period", 1, cyc >= per[i] - 4 && cyc <= per[i] + 4);
			chk("reset_out", 1, watchdog_reset);
			chk("irq_set", 1, irq);
			axr(8'h04, 32'h10);
			axw(8'h08, 32'h7);
			axr(8'h04, 32'h10);
			chk("irq_clear", 0, irq);
			axw(8'h04, 32'h0);
		end
		$display("test 2 done");
		axw(8'h04, 32'h20);
		for (int i = 0; i < 6; i++) begin
			waitp(24);
			chk("no_timeout", 24, cyc);
			core_model_inst.fire(i % 2 ? 3 : 0);
		end
		for (int k = 1; k < 3; k++) begin
			core_model_inst.fire(k);
			waitp(60);
			chk("wake", 1, wake_request);
			chk("wake_time", 1, cyc >= 28 && cyc <= 36);
			axr(8'h04, k == 1 ? 32'h38 : 32'h34);
			axw(8'h04, 32'h20);
		end
		core_model_inst.fire(1);
		core_model_inst.fire(5);
		axr(8'h10, 32'h0);
		axw(8'h04, 32'h20);
		core_model_inst.fire(4);
		axr(8'h04, 32'h0);
		chk("osc_off", 0, low_power_rc_clock_enable);
		$display("test 3 done");
		axw(8'h08, 32'h7);
		axw(8'h00, 32'h00);
		axw(8'h04, 32'h20);
		core_model_inst.fire(0);
		waitp(8);
		chk("early_clear", 1, watchdog_reset);
		axr(8'h08, 32'h2);
		axr(8'h04, 32'h0);
		axw(8'h04, 32'h20);
		waitp(27);
		core_model_inst.fire(0);
		waitp(6);
		chk("late_clear", 6, cyc);
		$display("test 4 done");
		axw(8'h00, 32'hc0);
		axw(8'h04, 32'h0);
		chk("hw_on", 1, low_power_rc_clock_enable);
		waitp(60);
		chk("hw_timeout", 1, watchdog_reset);
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		chk("ce_stall", 0, s_axi_arready);
		ce <= 1'b1;
		@(posedge clk);
		$display("test 5 done");
		give_verdict();
	end
endmodule : tb_top
